/* File: hw/mcuio_defines.svh */
// Register offsets, field positions, reset values and counts of the I/O port bank
`ifndef MCUIO_DEFINES_SVH
`define MCUIO_DEFINES_SVH
`define MCUIO_OFS_C_CFG 8'h00
`define MCUIO_OFS_C_DAT 8'h04
`define MCUIO_OFS_C_PIN 8'h08
`define MCUIO_OFS_G_CFG 8'h0c
`define MCUIO_OFS_G_DAT 8'h10
`define MCUIO_OFS_G_PIN 8'h14
`define MCUIO_OFS_L_CFG 8'h18
`define MCUIO_OFS_L_DAT 8'h1c
`define MCUIO_OFS_L_PIN 8'h20
`define MCUIO_OFS_D_DAT 8'h24
`define MCUIO_OFS_I_PIN 8'h28
`define MCUIO_OFS_STATUS 8'h2c
`define MCUIO_G_HALT_BIT 7
`define MCUIO_G_IDLE_BIT 6
`define MCUIO_G_ALT_SK_BIT 6
`define MCUIO_G_DLY_BIT 7
`define MCUIO_G_WDOG_PIN 1
`define MCUIO_G_SO_PIN 4
`define MCUIO_G_IN_PIN 6
`define MCUIO_G_OSC_PIN 7
`define MCUIO_L_TX_PIN 2
`define MCUIO_CFG_RESET 8'h00
`define MCUIO_DAT_RESET 8'h00
`define MCUIO_D_RESET 8'hff
`define MCUIO_RESTART_DELAY_CYCLES 10'd256
`endif

/* File: hw/mcuio_pkg.sv */
// Types of the I/O port bank
package mcuio_pkg;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] c_cfg;
    logic [7:0] c_dat;
    logic [7:0] g_cfg;
    logic [7:0] g_dat;
    logic [7:0] l_cfg;
    logic [7:0] l_dat;
    logic [7:0] d_dat;
    logic [7:0] c_out;
    logic [7:0] c_oe_n;
    logic [7:0] c_pull;
    logic [7:0] g_out;
    logic [7:0] g_oe_n;
    logic [7:0] g_pull;
    logic [7:0] l_out;
    logic [7:0] l_oe_n;
    logic [7:0] l_pull;
    logic halt;
    logic idle;
    logic dly_busy;
    logic [9:0] dly_cnt;
    logic g7_prev;
    logic [7:0] wakeup;
    logic [10:0] alt_in;
    logic [2:0] comp1;
    logic [2:0] comp2;
  } mcuio_state_type;
endpackage

/* File: hw/mcuio_pin_cell.sv */
// Per-bit pin set-up decode from configuration and data bits
`timescale 1ns/1ps
module mcuio_pin_cell (
  input wire logic [7:0] cfg,
  input wire logic [7:0] dat,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pin_pull
);
  // 0,0 hi-z input; 0,1 weak pull-up; 1,0 drive low; 1,1 drive high
  always_comb
  begin
    pin_out = cfg & dat;
    pin_oe_n = ~cfg;
    pin_pull = ~cfg & dat;
  end
endmodule

/* File: hw/mcuio_port_bank.sv */
// I/O port bank: ports C, G, L (bidirectional), D (output), I (input)
`timescale 1ns/1ps
`include "mcuio_defines.svh"
// Notes on behaviour
// RULE1: cfg,data pair picks hi-z/pull-up/low/high
// RULE2: each bidirectional port has cfg and data registers
// RULE3: separate read-only location returns pin levels
// RULE4: writing one to G data bit7 halts
// RULE5: writing one to G data bit6 idles
// RULE6: G config bit6 selects alternate shift-clock phase
// RULE7: G config bit7 adds restart delay, R/C
// RULE8: G data bits 6,7 read zero
// RULE9: G: five I/O, pin6 input, pin1 fixed output
// RULE10: G pin1 driven only by watchdog error
// RULE11: crystal option: G pin7 is clock output
// RULE12: R/C option: G pin7 input, rise wakes halt
// RULE13: G pins carry serial, timer, interrupt functions
// RULE14: all L pins feed wakeup, Schmitt inputs
// RULE15: L pins route to USART and timers 2,3
// RULE16: port D output-only, high during reset
// RULE17: port I input-only, no drivers
// RULE18: port I pins serve two comparators
// RULE19: unbonded port C bits read arbitrary
// RULE20: reset clears C,G,L registers, pins hi-z
// RULE21: registers read back last written value
module mcuio_port_bank
  import mcuio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe_n,
  output logic [7:0] port_c_pullup,
  input wire logic [7:0] port_g_in,
  output logic [7:0] port_g_out,
  output logic [7:0] port_g_oe_n,
  output logic [7:0] port_g_pullup,
  input wire logic [7:0] port_l_in,
  output logic [7:0] port_l_out,
  output logic [7:0] port_l_oe_n,
  output logic [7:0] port_l_pullup,
  output logic [7:0] port_d_out,
  input wire logic [7:0] port_i_in,
  input wire logic osc_rc_option,
  input wire logic oscillator_clock_input,
  input wire logic watchdog_error_n,
  input wire logic wake_request,
  input wire logic serial_data_out,
  input wire logic serial_out_enable,
  input wire logic usart_transmit_pin,
  input wire logic usart_transmit_enable,
  output logic halt_state,
  output logic idle_state,
  output logic halt_restart_delay_active,
  output logic halt_restart_delay_enable,
  output logic serial_shift_phase_alt,
  output logic external_interrupt_input,
  output logic timer1_capture_input,
  output logic timer1_io,
  output logic serial_data_in,
  output logic serial_shift_clock,
  output logic usart_external_clock,
  output logic usart_receive_pin,
  output logic timer2_input_first,
  output logic timer2_input_second,
  output logic timer3_input_first,
  output logic timer3_input_second,
  output logic [7:0] multi_input_wakeup,
  output logic [2:0] comparator_one_pins,
  output logic [2:0] comparator_two_pins
);

  mcuio_state_type s_q;
  mcuio_state_type s_d;

  // Reset image is a constant so the asynchronous branch loads no logic
  localparam mcuio_state_type reset_image = '{
    c_cfg: `MCUIO_CFG_RESET, // RULE20
    c_dat: `MCUIO_DAT_RESET,
    g_cfg: `MCUIO_CFG_RESET,
    g_dat: `MCUIO_DAT_RESET,
    l_cfg: `MCUIO_CFG_RESET,
    l_dat: `MCUIO_DAT_RESET,
    c_oe_n: 8'hff,
    g_oe_n: 8'hff,
    l_oe_n: 8'hff,
    d_dat: `MCUIO_D_RESET, // RULE16
    default: '0
  };

  logic setup_ph;
  logic access_ph;
  logic wr;
  logic g7_rise;
  logic leave_halt;
  logic [7:0] c_cfg_nx;
  logic [7:0] c_dat_nx;
  logic [7:0] g_cfg_nx;
  logic [7:0] g_dat_nx;
  logic [7:0] l_cfg_nx;
  logic [7:0] l_dat_nx;

  logic [7:0] c_cell_out;
  logic [7:0] c_cell_oe_n;
  logic [7:0] c_cell_pull;
  logic [7:0] g_cell_out;
  logic [7:0] g_cell_oe_n;
  logic [7:0] g_cell_pull;
  logic [7:0] l_cell_out;
  logic [7:0] l_cell_oe_n;
  logic [7:0] l_cell_pull;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, `MCUIO_OFS_C_CFG) | hit(addr, `MCUIO_OFS_C_DAT) |
      hit(addr, `MCUIO_OFS_C_PIN) | hit(addr, `MCUIO_OFS_G_CFG) |
      hit(addr, `MCUIO_OFS_G_DAT) | hit(addr, `MCUIO_OFS_G_PIN) |
      hit(addr, `MCUIO_OFS_L_CFG) | hit(addr, `MCUIO_OFS_L_DAT) |
      hit(addr, `MCUIO_OFS_L_PIN) | hit(addr, `MCUIO_OFS_D_DAT) |
      hit(addr, `MCUIO_OFS_I_PIN) | hit(addr, `MCUIO_OFS_STATUS);
  endfunction

  function automatic logic read_only(input logic [7:0] addr);
    read_only = hit(addr, `MCUIO_OFS_C_PIN) | hit(addr, `MCUIO_OFS_G_PIN) |
      hit(addr, `MCUIO_OFS_L_PIN) | hit(addr, `MCUIO_OFS_I_PIN) |
      hit(addr, `MCUIO_OFS_STATUS);
  endfunction

  // Cells see next-state registers so pin drive lands with the write edge
  mcuio_pin_cell u_cell_c (
    .cfg(c_cfg_nx),
    .dat(c_dat_nx),
    .pin_out(c_cell_out),
    .pin_oe_n(c_cell_oe_n),
    .pin_pull(c_cell_pull)
  );

  mcuio_pin_cell u_cell_g (
    .cfg(g_cfg_nx),
    .dat(g_dat_nx),
    .pin_out(g_cell_out),
    .pin_oe_n(g_cell_oe_n),
    .pin_pull(g_cell_pull)
  );

  mcuio_pin_cell u_cell_l (
    .cfg(l_cfg_nx),
    .dat(l_dat_nx),
    .pin_out(l_cell_out),
    .pin_oe_n(l_cell_oe_n),
    .pin_pull(l_cell_pull)
  );

  function automatic logic [7:0] reg_next(
    input logic [7:0] cur,
    input logic sel,
    input logic [7:0] val
  );
    reg_next = sel ? val : cur;
  endfunction

  // Next register values kept apart from s_d so the pin cells form no loop
  // Writes take effect only at the access edge
  always_comb
  begin
    setup_ph = psel & ~penable;
    access_ph = psel & penable & s_q.pready;
    wr = access_ph & pwrite & mapped(paddr) & ~read_only(paddr);
    c_cfg_nx = reg_next(s_q.c_cfg, wr & hit(paddr, `MCUIO_OFS_C_CFG), pwdata[7:0]); // RULE2
    c_dat_nx = reg_next(s_q.c_dat, wr & hit(paddr, `MCUIO_OFS_C_DAT), pwdata[7:0]);
    g_cfg_nx = reg_next(s_q.g_cfg, wr & hit(paddr, `MCUIO_OFS_G_CFG), pwdata[7:0]);
    // Bits 6 and 7 are commands, not stored
    g_dat_nx = reg_next(s_q.g_dat, wr & hit(paddr, `MCUIO_OFS_G_DAT),
      {2'b00, pwdata[5:0]}); // RULE8
    l_cfg_nx = reg_next(s_q.l_cfg, wr & hit(paddr, `MCUIO_OFS_L_CFG), pwdata[7:0]);
    l_dat_nx = reg_next(s_q.l_dat, wr & hit(paddr, `MCUIO_OFS_L_DAT), pwdata[7:0]);
  end

  always_comb
  begin
    s_d = s_q;

    // Zero-wait slave: answer prepared in setup, presented in access
    s_d.pready = setup_ph;
    s_d.pslverr = setup_ph & (~mapped(paddr) | (pwrite & read_only(paddr)));
    s_d.prdata = '0;
    if (setup_ph & ~pwrite)
    begin
      case (1'b1)
        hit(paddr, `MCUIO_OFS_C_CFG): s_d.prdata[7:0] = s_q.c_cfg; // RULE21
        hit(paddr, `MCUIO_OFS_C_DAT): s_d.prdata[7:0] = s_q.c_dat;
        hit(paddr, `MCUIO_OFS_C_PIN): s_d.prdata[7:0] = port_c_in; // RULE3 RULE19
        hit(paddr, `MCUIO_OFS_G_CFG): s_d.prdata[7:0] = s_q.g_cfg;
        hit(paddr, `MCUIO_OFS_G_DAT): s_d.prdata[7:0] = {2'b00, s_q.g_dat[5:0]}; // RULE8
        hit(paddr, `MCUIO_OFS_G_PIN): s_d.prdata[7:0] = port_g_in;
        hit(paddr, `MCUIO_OFS_L_CFG): s_d.prdata[7:0] = s_q.l_cfg;
        hit(paddr, `MCUIO_OFS_L_DAT): s_d.prdata[7:0] = s_q.l_dat;
        hit(paddr, `MCUIO_OFS_L_PIN): s_d.prdata[7:0] = port_l_in;
        hit(paddr, `MCUIO_OFS_D_DAT): s_d.prdata[7:0] = s_q.d_dat;
        hit(paddr, `MCUIO_OFS_I_PIN): s_d.prdata[7:0] = port_i_in; // RULE17
        hit(paddr, `MCUIO_OFS_STATUS):
          s_d.prdata[7:0] = {4'h0, osc_rc_option, s_q.dly_busy, s_q.idle, s_q.halt};
        default: s_d.prdata = '0;
      endcase
    end

    s_d.c_cfg = c_cfg_nx; // RULE2
    s_d.c_dat = c_dat_nx;
    s_d.g_cfg = g_cfg_nx;
    s_d.g_dat = g_dat_nx; // RULE8
    s_d.l_cfg = l_cfg_nx;
    s_d.l_dat = l_dat_nx;
    s_d.d_dat = reg_next(s_q.d_dat, wr & hit(paddr, `MCUIO_OFS_D_DAT), pwdata[7:0]); // RULE16

    // Halt and idle; a new request wins over a wake in the same cycle
    g7_rise = osc_rc_option & port_g_in[`MCUIO_G_OSC_PIN] & ~s_q.g7_prev; // RULE12
    s_d.g7_prev = port_g_in[`MCUIO_G_OSC_PIN];
    leave_halt = s_q.halt & (wake_request | g7_rise);
    if (s_q.dly_busy)
    begin
      s_d.dly_cnt = s_q.dly_cnt - 10'd1;
      if (s_q.dly_cnt == 10'd1)
      begin
        s_d.dly_busy = 1'b0;
      end
    end
    if (leave_halt)
    begin
      s_d.halt = 1'b0;
      // Delay only matters for the R/C oscillator start-up
      if (s_q.g_cfg[`MCUIO_G_DLY_BIT] & osc_rc_option) // RULE7
      begin
        s_d.dly_busy = 1'b1;
        s_d.dly_cnt = `MCUIO_RESTART_DELAY_CYCLES;
      end
    end
    if (wake_request)
    begin
      s_d.idle = 1'b0;
    end
    if (wr & hit(paddr, `MCUIO_OFS_G_DAT) & pwdata[`MCUIO_G_HALT_BIT]) // RULE4
    begin
      s_d.halt = 1'b1;
    end
    if (wr & hit(paddr, `MCUIO_OFS_G_DAT) & pwdata[`MCUIO_G_IDLE_BIT]) // RULE5
    begin
      s_d.idle = 1'b1;
    end

    s_d.c_out = c_cell_out; // RULE1
    s_d.c_oe_n = c_cell_oe_n;
    s_d.c_pull = c_cell_pull;
    s_d.l_out = l_cell_out;
    s_d.l_oe_n = l_cell_oe_n;
    s_d.l_pull = l_cell_pull;
    if (usart_transmit_enable) // RULE15
    begin
      s_d.l_out[`MCUIO_L_TX_PIN] = usart_transmit_pin;
      s_d.l_oe_n[`MCUIO_L_TX_PIN] = 1'b0;
      s_d.l_pull[`MCUIO_L_TX_PIN] = 1'b0;
    end

    s_d.g_out = g_cell_out; // RULE9
    s_d.g_oe_n = g_cell_oe_n;
    s_d.g_pull = g_cell_pull;
    if (serial_out_enable) // RULE13
    begin
      s_d.g_out[`MCUIO_G_SO_PIN] = serial_data_out;
      s_d.g_oe_n[`MCUIO_G_SO_PIN] = 1'b0;
      s_d.g_pull[`MCUIO_G_SO_PIN] = 1'b0;
    end
    // Error output only ever pulls low, otherwise floats
    s_d.g_out[`MCUIO_G_WDOG_PIN] = 1'b0; // RULE10
    s_d.g_oe_n[`MCUIO_G_WDOG_PIN] = watchdog_error_n;
    s_d.g_pull[`MCUIO_G_WDOG_PIN] = 1'b0;
    s_d.g_out[`MCUIO_G_IN_PIN] = 1'b0; // RULE9
    s_d.g_oe_n[`MCUIO_G_IN_PIN] = 1'b1;
    s_d.g_pull[`MCUIO_G_IN_PIN] = 1'b0;
    s_d.g_out[`MCUIO_G_OSC_PIN] = osc_rc_option ? 1'b0 : oscillator_clock_input; // RULE11
    s_d.g_oe_n[`MCUIO_G_OSC_PIN] = osc_rc_option; // RULE12
    s_d.g_pull[`MCUIO_G_OSC_PIN] = 1'b0;

    // Alternate inputs pass through one flop; the bank adds one cycle
    s_d.alt_in = {port_g_in[0], port_g_in[2], port_g_in[3], port_g_in[6],
      port_g_in[5], port_l_in[1], port_l_in[3], port_l_in[4], port_l_in[5],
      port_l_in[6], port_l_in[7]}; // RULE13 RULE15
    s_d.wakeup = port_l_in; // RULE14
    s_d.comp1 = port_i_in[3:1]; // RULE18
    s_d.comp2 = port_i_in[6:4];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= reset_image; // RULE20
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Schmitt buffering of L and G inputs is in the pad, not modelled here
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign port_c_out = s_q.c_out;
  assign port_c_oe_n = s_q.c_oe_n;
  assign port_c_pullup = s_q.c_pull;
  assign port_g_out = s_q.g_out;
  assign port_g_oe_n = s_q.g_oe_n;
  assign port_g_pullup = s_q.g_pull;
  assign port_l_out = s_q.l_out;
  assign port_l_oe_n = s_q.l_oe_n;
  assign port_l_pullup = s_q.l_pull;
  assign port_d_out = s_q.d_dat; // RULE16
  assign halt_state = s_q.halt;
  assign idle_state = s_q.idle;
  assign halt_restart_delay_active = s_q.dly_busy;
  assign halt_restart_delay_enable = s_q.g_cfg[`MCUIO_G_DLY_BIT];
  assign serial_shift_phase_alt = s_q.g_cfg[`MCUIO_G_ALT_SK_BIT]; // RULE6
  assign external_interrupt_input = s_q.alt_in[10];
  assign timer1_capture_input = s_q.alt_in[9];
  assign timer1_io = s_q.alt_in[8];
  assign serial_data_in = s_q.alt_in[7];
  assign serial_shift_clock = s_q.alt_in[6];
  assign usart_external_clock = s_q.alt_in[5];
  assign usart_receive_pin = s_q.alt_in[4];
  assign timer2_input_first = s_q.alt_in[3];
  assign timer2_input_second = s_q.alt_in[2];
  assign timer3_input_first = s_q.alt_in[1];
  assign timer3_input_second = s_q.alt_in[0];
  assign multi_input_wakeup = s_q.wakeup;
  assign comparator_one_pins = s_q.comp1;
  assign comparator_two_pins = s_q.comp2;

endmodule

/* File: verif/mcuio_props.sv */
// Concurrent checks on the ports of the I/O port bank
`timescale 1ns/1ps
module mcuio_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [7:0] port_c_oe_n,
  input wire logic [7:0] port_g_oe_n,
  input wire logic [7:0] port_d_out,
  input wire logic watchdog_error_n,
  input wire logic halt_state,
  input wire logic idle_state,
  input wire logic halt_restart_delay_enable,
  input wire logic serial_shift_phase_alt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic [31:0] pwdata_q;
  assign acc = psel && penable && pready;
  // Write data of the previous edge, for checks one cycle after a write
  always_ff @(posedge pclk) pwdata_q <= pwdata;
  ready_one_cycle_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready timing off");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h2c |=> pslverr && pready)
    else $error("unmapped access not refused");
  halt_entry_a: assert property (acc && pwrite && paddr == 8'h10 && pwdata[7] |=> halt_state)
    else $error("halt not entered");
  idle_entry_a: assert property (acc && pwrite && paddr == 8'h10 && pwdata[6] |=> idle_state)
    else $error("idle not entered");
  gdat_read_zero_a: assert property (acc && !pwrite && paddr == 8'h10 |-> prdata[7:6] == 2'b00)
    else $error("port g data top bits not zero");
  c_cfg_drive_a: assert property (acc && pwrite && paddr == 8'h00
    |=> port_c_oe_n == ~pwdata_q[7:0])
    else $error("port c drive enable wrong");
  g_special_bits_a: assert property (acc && pwrite && paddr == 8'h0c
    |=> {halt_restart_delay_enable, serial_shift_phase_alt} == pwdata_q[7:6])
    else $error("port g special config bits wrong");
  d_reset_high_a: assert property ($rose(presetn) |-> port_d_out == 8'hff)
    else $error("port d not high after reset");
  wdog_pin_a: assert property (1'b1 |=> port_g_oe_n[1] == $past(watchdog_error_n))
    else $error("error pin does not follow watchdog");
  cover property (acc && pwrite && paddr == 8'h10 && pwdata[7]);
  cover property (pslverr);
  cover property ($fell(halt_state));
endmodule
bind mcuio_port_bank mcuio_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .port_c_oe_n(port_c_oe_n), .port_g_oe_n(port_g_oe_n), .port_d_out(port_d_out),
  .watchdog_error_n(watchdog_error_n), .halt_state(halt_state), .idle_state(idle_state),
  .halt_restart_delay_enable(halt_restart_delay_enable),
  .serial_shift_phase_alt(serial_shift_phase_alt)
);

/* File: verif/mcuio_pins_model.sv */
// Board-side model of one 8-pin bidirectional port
`timescale 1ns/1ps
module mcuio_pins_model (
  input wire logic pclk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pull,
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] lvl
);
  logic [7:0] float_q = 8'h55;
  // A floating pin keeps moving so a stale level never passes as valid
  always @(posedge pclk) float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 8; i++)
      lvl[i] = !oe_n[i] ? out[i] : ext_en[i] ? ext[i] : pull[i] ? 1'b1 : float_q[i];
endmodule

/* File: verif/mcuio_port_bank_tb.sv */
// Self-checking bench of the I/O port bank
`timescale 1ns/1ps
module mcuio_port_bank_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h8b944cd9;
  logic pready, pslverr, halt_state, idle_state, halt_restart_delay_active;
  logic halt_restart_delay_enable, serial_shift_phase_alt, external_interrupt_input;
  logic timer1_capture_input, timer1_io, serial_data_in, serial_shift_clock;
  logic usart_external_clock, usart_receive_pin, timer2_input_first, timer2_input_second;
  logic timer3_input_first, timer3_input_second;
  logic osc_rc_option = 1'b1, oscillator_clock_input = 1'b0, watchdog_error_n = 1'b1;
  logic wake_request = 1'b0, serial_data_out = 1'b0, serial_out_enable = 1'b0;
  logic usart_transmit_pin = 1'b0, usart_transmit_enable = 1'b0;
  logic [7:0] port_c_in, port_c_out, port_c_oe_n, port_c_pullup, port_g_in, port_g_out;
  logic [7:0] port_g_oe_n, port_g_pullup, port_l_in, port_l_out, port_l_oe_n, port_l_pullup;
  logic [7:0] port_d_out, multi_input_wakeup, cx = 8'h00, gx = 8'h00, gen = 8'h80;
  logic [7:0] port_i_in = 8'h00, ag;
  logic [2:0] comparator_one_pins, comparator_two_pins;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h18, 8'h1c};
  logic [64:0] notes [$];
  logic [64:0] nt;
  int mismatches = 0, tests_run = 0, cycles = 0, n;
  always #4 pclk = ~pclk;
  mcuio_port_bank dut (.*);
  mcuio_pins_model pc (.pclk(pclk), .out(port_c_out), .oe_n(port_c_oe_n), .pull(port_c_pullup),
    .ext(cx), .ext_en(8'hff), .lvl(port_c_in));
  mcuio_pins_model pg (.pclk(pclk), .out(port_g_out), .oe_n(port_g_oe_n), .pull(port_g_pullup),
    .ext(gx), .ext_en(gen), .lvl(port_g_in));
  mcuio_pins_model pl (.pclk(pclk), .out(port_l_out), .oe_n(port_l_oe_n), .pull(port_l_pullup),
    .ext(cx), .ext_en(8'hff), .lvl(port_l_in));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task finish_test;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cp(input logic [7:0] got, input logic [7:0] exp);
    chk({25'h0, got}, {25'h0, exp});
  endtask
  // Note holds {error, data mask, data}; the monitor pops it when pready shows
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] e);
    @(posedge pclk);
    notes.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 65'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, 32'hffffffff, x});
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      nt = notes.pop_front();
      chk({pslverr, prdata & nt[63:32]}, {nt[64], nt[31:0] & nt[63:32]});
    end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    cp(port_d_out, 8'hff);
    cp(port_c_oe_n & port_g_oe_n & port_l_oe_n, 8'hff);
    presetn <= 1'b1;
    foreach (ofs[i])
      rd(ofs[i], 32'h0);
    $display("reset test done");
    for (int p = 0; p < 2; p++)
      repeat (4)
      begin
        rs = xs(rs);
        cx <= rs[23:16];
        wr(p ? 8'h18 : 8'h00, rs[7:0]);
        wr(p ? 8'h1c : 8'h04, rs[15:8]);
        rd(p ? 8'h18 : 8'h00, {24'h0, rs[7:0]});
        rd(p ? 8'h1c : 8'h04, {24'h0, rs[15:8]});
        rd(p ? 8'h20 : 8'h08, {24'h0, rs[7:0] & rs[15:8] | ~rs[7:0] & rs[23:16]});
        cp(p ? port_l_oe_n : port_c_oe_n, ~rs[7:0]);
        cp(p ? port_l_pullup : port_c_pullup, ~rs[7:0] & rs[15:8]);
        cp((p ? port_l_out : port_c_out) & rs[7:0], rs[15:8] & rs[7:0]);
        if (p)
          cp(multi_input_wakeup, port_l_in);
      end
    $display("port set-up test done");
    wr(8'h0c, 8'hc0);
    rd(8'h0c, 32'hc0);
    cp({6'h0, halt_restart_delay_enable, serial_shift_phase_alt}, 8'h03);
    wr(8'h10, 8'hff);
    apb(1'b0, 8'h10, 32'h0, {1'b0, 32'hc0, 32'h0});
    cp({6'h0, halt_state, idle_state}, 8'h03);
    rd(8'h2c, 32'h0b);
    gx <= 8'h80;
    for (n = 0; halt_state !== 1'b0 && n < 10; n++)
      @(posedge pclk);
    cp({6'h0, halt_state, halt_restart_delay_active}, 8'h01);
    for (n = 0; halt_restart_delay_active === 1'b1 && n < 300; n++)
      @(posedge pclk);
    cp({7'h0, n > 250 && n < 258}, 8'h01);
    wake_request <= 1'b1;
    repeat (2) @(posedge pclk);
    wake_request <= 1'b0;
    cp({7'h0, idle_state}, 8'h00);
    $display("low-power test done");
    osc_rc_option <= 1'b0;
    gen <= 8'h00;
    oscillator_clock_input <= 1'b1;
    watchdog_error_n <= 1'b0;
    repeat (3) @(posedge pclk);
    cp({4'h0, port_g_oe_n[7], port_g_out[7], port_g_oe_n[1], port_g_out[1]}, 8'h04);
    watchdog_error_n <= 1'b1;
    wr(8'h18, 8'h00);
    rs = xs(rs);
    gx <= rs[7:0];
    gen <= 8'h7d;
    cx <= rs[15:8];
    serial_data_out <= rs[16];
    serial_out_enable <= 1'b1;
    usart_transmit_pin <= rs[17];
    usart_transmit_enable <= 1'b1;
    repeat (3) @(posedge pclk);
    ag = {3'h0, external_interrupt_input, timer1_capture_input, timer1_io, serial_shift_clock,
      serial_data_in};
    cp(ag, {3'h0, rs[0], rs[2], rs[3], rs[5], rs[6]});
    ag = {usart_external_clock, usart_receive_pin, timer2_input_first, timer2_input_second,
      timer3_input_first, timer3_input_second, 2'h0};
    cp(ag, {rs[9], rs[11], rs[12], rs[13], rs[14], rs[15], 2'h0});
    ag = {4'h0, port_g_oe_n[4], port_g_out[4], port_l_oe_n[2], port_l_out[2]};
    cp(ag, {5'h0, rs[16], 1'b0, rs[17]});
    cp(port_g_pullup, 8'h2d);
    cp(multi_input_wakeup, {rs[15:11], rs[17], rs[9:8]});
    serial_out_enable <= 1'b0;
    usart_transmit_enable <= 1'b0;
    rs = xs(rs);
    port_i_in <= rs[7:0];
    wr(8'h24, rs[15:8]);
    rd(8'h28, {24'h0, rs[7:0]});
    cp(port_d_out, rs[15:8]);
    cp({2'h0, comparator_two_pins, comparator_one_pins}, {2'h0, rs[6:1]});
    apb(1'b0, 8'h30, 32'h0, {1'b1, 64'h0});
    apb(1'b1, 8'h08, 32'hff, {1'b1, 64'h0});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cp(port_d_out, 8'hff);
    presetn <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h0c, 32'h0);
    @(posedge pclk);
    cp(8'(notes.size()), 8'h00);
    $display("pin and refusal test done");
    finish_test;
  end
endmodule
